// ==== design/swm_pkg.sv ====
// package of the single-wire write master: timing, mode fields and carriers
// assumes a 200 MHz system clock; counts are derived from times in ns
`default_nettype none
package swm_pkg;
    // ***************************************
    // timing
    // ***************************************
    localparam int CLK_NS       = 5;
    localparam int T_RST_NS     = 480000;  // reset low time, least
    localparam int T_PRES_NS    = 70000;   // release to presence sample
    localparam int T_RSTREC_NS  = 410000;  // rest of presence window
    localparam int T_SLOT_NS    = 60000;   // write slot, least
    localparam int T_W1_NS      = 6000;    // low time of a one
    localparam int T_REC_NS     = 5000;    // recovery between slots
    localparam int RST_CYC      = (T_RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int PRES_CYC     = T_PRES_NS / CLK_NS;
    localparam int RSTREC_CYC   = (T_RSTREC_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLOT_CYC     = (T_SLOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int W1_CYC       = (T_W1_NS + CLK_NS - 1) / CLK_NS;
    localparam int REC_CYC      = (T_REC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W        = 17;

    // ***************************************
    // mode and array layout
    // ***************************************
    localparam int MODE_PRE_BIT  = 0;
    localparam int MODE_POST_BIT = 1;
    localparam int MODE_BIT_BIT  = 2;
    localparam int ARR_DEPTH     = 16;
    localparam int IDX_W         = 4;
    localparam int LIM_W         = 5;
    localparam logic [LIM_W-1:0] ARR_FULL = 5'h10;

    typedef struct packed {
        logic             is_array;   // source is the array store
        logic             has_count;  // explicit element count given
        logic [LIM_W-1:0] count;      // elements to send when has_count
        logic [7:0]       data;       // plain item value
        logic             last;       // final item of the list
    } swm_item_t;

    typedef enum logic [2:0] {
        S_IDLE, S_RST_LOW, S_RST_WAIT, S_RST_REC, S_FETCH, S_SLOT_LOW, S_SLOT_REL
    } swm_state_t;
endpackage
`default_nettype wire

// ==== design/swm_write_master.sv ====
// single-wire bus write master: reset/presence, byte or bit write slots
// assumes one clock, an external pull-up on the line, slaves on the far side
`default_nettype none
module swm_write_master #(
    parameter int RST_CYCLES    = swm_pkg::RST_CYC,
    parameter int PRES_CYCLES   = swm_pkg::PRES_CYC,
    parameter int RSTREC_CYCLES = swm_pkg::RSTREC_CYC,
    parameter int SLOT_CYCLES   = swm_pkg::SLOT_CYC,
    parameter int W1_CYCLES     = swm_pkg::W1_CYC,
    parameter int REC_CYCLES    = swm_pkg::REC_CYC
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        srst,
    // command
    input  wire logic                        start,
    input  wire logic [2:0]                  mode,
    output var  logic                        busy,
    output var  logic                        done,
    output var  logic                        no_presence,
    // item stream
    input  wire logic                        item_valid,
    input  wire swm_pkg::swm_item_t          item,
    output var  logic                        item_ready,
    // array store write port
    input  wire logic                        arr_wr,
    input  wire logic [swm_pkg::IDX_W-1:0]   arr_idx,
    input  wire logic [7:0]                  arr_data,
    // bus line
    input  wire logic                        dq_in,
    output var  logic                        dq_out,
    output var  logic                        dq_oe_n
);
    import swm_pkg::*;

    localparam logic [CNT_W-1:0] C_RST  = CNT_W'(RST_CYCLES);
    localparam logic [CNT_W-1:0] C_PRES = CNT_W'(PRES_CYCLES);
    localparam logic [CNT_W-1:0] C_RREC = CNT_W'(RSTREC_CYCLES);
    localparam logic [CNT_W-1:0] C_W0   = CNT_W'(SLOT_CYCLES);
    localparam logic [CNT_W-1:0] C_W1   = CNT_W'(W1_CYCLES);
    localparam logic [CNT_W-1:0] C_REC  = CNT_W'(REC_CYCLES);

    // ***************************************
    // array store
    // ***************************************
    logic [7:0] arr [ARR_DEPTH];
    genvar gi;
    generate
        for (gi = 0; gi < ARR_DEPTH; gi++) begin : g_arr
            always_ff @(posedge clk) begin
                if (srst) begin
                    arr[gi] <= 8'h00;
                end else if (arr_wr && arr_idx == IDX_W'(gi)) begin
                    arr[gi] <= arr_data;
                end
            end
        end
    endgenerate

    // ***************************************
    // line input synchroniser
    // ***************************************
    logic dq_meta, dq_sync;
    always_ff @(posedge clk) begin
        if (srst) begin
            dq_meta <= 1'b1;
            dq_sync <= 1'b1;
        end else begin
            dq_meta <= dq_in;
            dq_sync <= dq_meta;
        end
    end

    // ***************************************
    // sequencer
    // ***************************************
    swm_state_t       st, next_st;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [2:0]       md, next_md;
    logic             post, next_post;     // reset in progress is the closing one
    logic             seen, next_seen;
    logic [7:0]       shreg, next_shreg;
    logic [2:0]       bitcnt, next_bitcnt;
    logic             cur_arr, next_cur_arr;
    logic             cur_last, next_cur_last;
    logic [LIM_W-1:0] elem_idx, next_elem_idx;
    logic [LIM_W-1:0] elem_lim, next_elem_lim;
    logic             next_busy, next_done, next_nop, next_ready, next_oe_n;

    always_comb begin
        next_st       = st;
        next_cnt      = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
        next_md       = md;
        next_post     = post;
        next_seen     = seen;
        next_shreg    = shreg;
        next_bitcnt   = bitcnt;
        next_cur_arr  = cur_arr;
        next_cur_last = cur_last;
        next_elem_idx = elem_idx;
        next_elem_lim = elem_lim;
        next_busy     = busy;
        next_done     = 1'b0;
        next_nop      = no_presence;
        next_ready    = 1'b0;
        next_oe_n     = 1'b1;
        case (st)
            S_IDLE: begin
                if (start) begin
                    next_md   = mode;
                    next_busy = 1'b1;
                    // a byte run leaves the bit counter at 7; clear it before a bit run starts
                    next_bitcnt = 3'd0;
                    next_nop  = 1'b0;
                    next_post = 1'b0;
                    if (mode[MODE_PRE_BIT]) begin
                        next_st   = S_RST_LOW;
                        next_cnt  = C_RST;
                        next_oe_n = 1'b0;
                    end else begin
                        next_st    = S_FETCH;
                        next_ready = 1'b1;
                    end
                end
            end
            S_RST_LOW: begin
                next_oe_n = 1'b0;
                if (cnt == CNT_W'(1)) begin
                    next_oe_n = 1'b1;
                    next_st   = S_RST_WAIT;
                    next_cnt  = C_PRES;
                    next_seen = 1'b0;
                end
            end
            S_RST_WAIT: begin
                if (cnt == CNT_W'(1)) begin
                    next_seen = !dq_sync;
                    next_st   = S_RST_REC;
                    next_cnt  = C_RREC;
                end
            end
            S_RST_REC: begin
                if (cnt == CNT_W'(1)) begin
                    if (!seen) begin
                        next_nop  = 1'b1;
                        next_busy = 1'b0;
                        next_done = 1'b1;
                        next_st   = S_IDLE;
                    end else if (post) begin
                        next_busy = 1'b0;
                        next_done = 1'b1;
                        next_st   = S_IDLE;
                    end else begin
                        next_st    = S_FETCH;
                        next_ready = 1'b1;
                    end
                end
            end
            S_FETCH: begin
                next_ready = 1'b1;
                if (item_valid && item_ready) begin
                    next_ready    = 1'b0;
                    next_cur_arr  = item.is_array;
                    next_cur_last = item.last;
                    next_bitcnt   = 3'd0;
                    next_elem_idx = '0;
                    // no count means the whole array
                    next_elem_lim = item.has_count ? item.count : ARR_FULL;
                    next_shreg    = item.is_array ? arr[0] : item.data;
                    if (item.is_array && item.has_count && item.count == '0) begin
                        next_ready = !item.last;
                        if (item.last) begin
                            next_st = S_IDLE;
                        end
                    end else begin
                        next_st   = S_SLOT_LOW;
                        next_oe_n = 1'b0;
                        next_cnt  = (item.is_array ? arr[0][0] : item.data[0]) ? C_W1 : C_W0;
                    end
                    if (item.is_array && item.has_count && item.count == '0 && item.last) begin
                        if (md[MODE_POST_BIT]) begin
                            next_st   = S_RST_LOW;
                            next_post = 1'b1;
                            next_cnt  = C_RST;
                            next_oe_n = 1'b0;
                        end else begin
                            next_busy = 1'b0;
                            next_done = 1'b1;
                        end
                    end
                end
            end
            S_SLOT_LOW: begin
                next_oe_n = 1'b0;
                if (cnt == CNT_W'(1)) begin
                    next_oe_n = 1'b1;
                    next_st   = S_SLOT_REL;
                    next_cnt  = (shreg[0] ? C_W0 - C_W1 : CNT_W'(0)) + C_REC;
                end
            end
            S_SLOT_REL: begin
                if (cnt == CNT_W'(1)) begin
                    if (!md[MODE_BIT_BIT] && bitcnt != 3'd7) begin
                        next_bitcnt = bitcnt + 3'd1;
                        next_shreg  = {1'b0, shreg[7:1]};
                        next_st     = S_SLOT_LOW;
                        next_oe_n   = 1'b0;
                        next_cnt    = shreg[1] ? C_W1 : C_W0;
                    end else if (cur_arr && elem_idx + LIM_W'(1) < elem_lim) begin
                        next_elem_idx = elem_idx + LIM_W'(1);
                        next_shreg    = arr[IDX_W'(elem_idx + LIM_W'(1))];
                        next_bitcnt   = 3'd0;
                        next_st       = S_SLOT_LOW;
                        next_oe_n     = 1'b0;
                        next_cnt      = arr[IDX_W'(elem_idx + LIM_W'(1))][0] ? C_W1 : C_W0;
                    end else if (!cur_last) begin
                        next_st    = S_FETCH;
                        next_ready = 1'b1;
                    end else if (md[MODE_POST_BIT]) begin
                        next_st   = S_RST_LOW;
                        next_post = 1'b1;
                        next_cnt  = C_RST;
                        next_oe_n = 1'b0;
                    end else begin
                        next_st   = S_IDLE;
                        next_busy = 1'b0;
                        next_done = 1'b1;
                    end
                end
            end
            default: begin
                next_st   = S_IDLE;
                next_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st          <= S_IDLE;
            cnt         <= '0;
            md          <= 3'h0;
            post        <= 1'b0;
            seen        <= 1'b0;
            shreg       <= 8'h00;
            bitcnt      <= 3'h0;
            cur_arr     <= 1'b0;
            cur_last    <= 1'b0;
            elem_idx    <= '0;
            elem_lim    <= '0;
            busy        <= 1'b0;
            done        <= 1'b0;
            no_presence <= 1'b0;
            item_ready  <= 1'b0;
            dq_oe_n     <= 1'b1;
            dq_out      <= 1'b0;
        end else begin
            st          <= next_st;
            cnt         <= next_cnt;
            md          <= next_md;
            post        <= next_post;
            seen        <= next_seen;
            shreg       <= next_shreg;
            bitcnt      <= next_bitcnt;
            cur_arr     <= next_cur_arr;
            cur_last    <= next_cur_last;
            elem_idx    <= next_elem_idx;
            elem_lim    <= next_elem_lim;
            busy        <= next_busy;
            done        <= next_done;
            no_presence <= next_nop;
            item_ready  <= next_ready;
            dq_oe_n     <= next_oe_n;
            dq_out      <= 1'b0;  // open drain: only ever pulls low
        end
    end

    // ***************************************
    // checks
    // ***************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_released_idle;
        (st == S_IDLE) |-> dq_oe_n;
    endproperty
    a_released_idle: assert property (p_released_idle) else $error("line driven while idle");

    property p_never_high;
        !(dq_out && !dq_oe_n);
    endproperty
    a_never_high: assert property (p_never_high) else $error("line driven high");

    property p_pre_reset;
        (st == S_IDLE && start) |=> (md[MODE_PRE_BIT] ? st == S_RST_LOW : st == S_FETCH);
    endproperty
    a_pre_reset: assert property (p_pre_reset) else $error("reset placement wrong");

    property p_reset_low;
        $rose(st == S_RST_LOW) |-> (!dq_oe_n)[*8];
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("reset pulse too short");

    property p_wait_released;
        (st == S_RST_WAIT || st == S_RST_REC) |-> dq_oe_n;
    endproperty
    a_wait_released: assert property (p_wait_released) else $error("data during presence window");

    property p_nop_stops;
        $rose(no_presence) |-> (st == S_IDLE && !busy && done);
    endproperty
    a_nop_stops: assert property (p_nop_stops) else $error("no presence did not abandon");

    property p_bit_mode;
        (busy && md[MODE_BIT_BIT]) |-> bitcnt == 3'd0;
    endproperty
    a_bit_mode: assert property (p_bit_mode) else $error("more than one bit per item");

    property p_lsb_first;
        (st == S_SLOT_REL && cnt == CNT_W'(1) && !md[MODE_BIT_BIT] && bitcnt != 3'd7)
            |=> (shreg == {1'b0, $past(shreg[7:1])}) && bitcnt == $past(bitcnt) + 3'd1;
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("byte not shifted lsb first");

    property p_arr_limit;
        (st == S_SLOT_LOW && cur_arr) |-> elem_idx < elem_lim;
    endproperty
    a_arr_limit: assert property (p_arr_limit) else $error("array element past its count");

    property p_slot_bit;
        $rose(st == S_SLOT_LOW) |-> !dq_oe_n ##1 !dq_oe_n;
    endproperty
    a_slot_bit: assert property (p_slot_bit) else $error("slot low not driven");
endmodule
`default_nettype wire

// ==== tb/swm_slave_model.sv ====
// behavioural slave on the shared single-wire line: presence answer and slot decoding
// assumes the bench resolves the line from all pull-downs and an idle pull-up
`default_nettype none
module swm_slave_model #(
    parameter int RST_MIN  = 30,
    parameter int BIT_TH   = 12,
    parameter int PRES_LEN = 20
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // control from the bench
    input  wire logic       present_en,
    input  wire logic [7:0] pres_delay,
    // bus line
    input  wire logic       line,
    output var  logic       pull_n,
    // decoded events: 0 or 1 a bit, 2 a reset
    output var  logic       ev_valid,
    output var  logic [2:0] ev_code
);
    timeunit 1ns;
    timeprecision 100ps;
    int low_cnt;
    int pw;
    int pc;

    // ***************************************
    // line watcher
    // ***************************************
    // our own presence pulse is not decoded, so the wait and pulse phases ignore the line
    always @(posedge clk) begin
        ev_valid <= 1'b0;
        if (srst) begin
            low_cnt <= 0;
            pw      <= 0;
            pc      <= 0;
            pull_n  <= 1'b1;
            ev_code <= 3'h0;
        end else if (pc != 0) begin
            pc <= pc - 1;
            if (pc == 1) pull_n <= 1'b1;
        end else if (pw != 0) begin
            pw <= pw - 1;
            if (pw == 1) begin
                pull_n <= 1'b0;
                pc     <= PRES_LEN;
            end
        end else if (line == 1'b0) begin
            low_cnt <= low_cnt + 1;
        end else if (low_cnt != 0) begin
            ev_valid <= 1'b1;
            low_cnt  <= 0;
            if (low_cnt >= RST_MIN) begin
                ev_code <= 3'h2;
                if (present_en) pw <= int'(pres_delay);
            end else begin
                ev_code <= (low_cnt < BIT_TH) ? 3'h1 : 3'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_single_wire_bus_write_master.sv ====
// self-checking bench of the single-wire write master against a slave model
// assumes short timing parameters; expected line events are queued and popped by a monitor
`default_nettype none
module tb_single_wire_bus_write_master;
    timeunit 1ns;
    timeprecision 100ps;
    import swm_pkg::*;
    localparam int LIM = 8000;
    logic clk, srst, start, busy, done, no_presence, item_valid, item_ready;
    logic arr_wr, dq_out, dq_oe_n, pull_n, present_en, ev_valid;
    logic [2:0] mode, ev_code;
    logic [3:0] arr_idx;
    logic [7:0] arr_data, pres_delay;
    swm_item_t item;
    wire logic line;
    logic [7:0] arr_model [16];
    logic [2:0] exp_q [$];
    swm_item_t q [$];
    int n_errors, num_checks, seed, i, m;

    // released line floats to the pull-up; any pull-down wins
    assign line = (dq_oe_n ? 1'b1 : dq_out) & pull_n;

    swm_write_master #(.RST_CYCLES(40), .PRES_CYCLES(12), .RSTREC_CYCLES(30), .SLOT_CYCLES(20),
        .W1_CYCLES(4), .REC_CYCLES(3)) dut (
        .clk(clk), .srst(srst), .start(start), .mode(mode), .busy(busy), .done(done),
        .no_presence(no_presence), .item_valid(item_valid), .item(item), .item_ready(item_ready),
        .arr_wr(arr_wr), .arr_idx(arr_idx), .arr_data(arr_data), .dq_in(line), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n));

    swm_slave_model slave (.clk(clk), .srst(srst), .present_en(present_en), .pres_delay(pres_delay),
        .line(line), .pull_n(pull_n), .ev_valid(ev_valid), .ev_code(ev_code));

    // ***************************************
    // checking
    // ***************************************
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic take(input logic [2:0] got);
        if (exp_q.size() == 0) check("event", 8'hff, {5'h00, got});
        else check("event", {5'h00, exp_q.pop_front()}, {5'h00, got});
    endtask

    // sampled mid-cycle so registered outputs have settled
    always @(negedge clk) begin
        if (ev_valid === 1'b1) take(ev_code);
        if (done === 1'b1) take({2'b10, no_presence});
    end

    task automatic summarize();
        if (exp_q.size() != 0) check("pending", 8'h00, 8'(exp_q.size()));
        if (n_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ***************************************
    // stimulus
    // ***************************************
    function automatic swm_item_t mk(input logic a, input logic c, input logic [4:0] n,
                                     input logic [7:0] d, input logic l);
        return '{is_array: a, has_count: c, count: n, data: d, last: l};
    endfunction

    task automatic run(input logic [2:0] md, input swm_item_t its [$]);
        int k, n, e;
        logic [7:0] b;
        if (md[0]) exp_q.push_back(3'd2);
        if (md[0] && !present_en) exp_q.push_back(3'd5);
        else begin
            foreach (its[j]) begin
                n = its[j].is_array ? (its[j].has_count ? int'(its[j].count) : 16) : 1;
                for (e = 0; e < n; e++) begin
                    b = its[j].is_array ? arr_model[e] : its[j].data;
                    if (md[2]) exp_q.push_back({2'b00, b[0]});
                    else for (k = 0; k < 8; k++) exp_q.push_back({2'b00, b[k]});
                end
            end
            if (md[1]) exp_q.push_back(3'd2);
            exp_q.push_back(3'd4);
        end
        mode  = md;
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        foreach (its[j]) begin
            if (md[0] && !present_en) break;
            item       = its[j];
            item_valid = 1'b1;
            for (k = 0; k < LIM && item_ready !== 1'b1; k++) begin
                @(posedge clk);
                #1;
            end
            if (k == LIM) begin n_errors++; summarize(); end
            @(posedge clk);
            #1 item_valid = 1'b0;
            // a start while busy must be ignored, with a different mode on the pins
            start = 1'b1;
            mode  = ~md;
            @(posedge clk);
            #1 start = 1'b0;
        end
        for (k = 0; k < LIM && done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (k == LIM) begin n_errors++; summarize(); end
        check("busy", 8'h00, {7'h00, busy});
        check("dq_oe_n", 8'h01, {7'h00, dq_oe_n});
        check("dq_out", 8'h00, {7'h00, dq_out});
        repeat (3) @(posedge clk);
        #1;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        seed = 32'h51fe_94c6;
        {srst, start, mode, item_valid, item, arr_wr, arr_idx, arr_data} = '0;
        srst = 1'b1;
        present_en = 1'b1;
        pres_delay = 8'h02;
        n_errors = 0;
        num_checks = 0;
        repeat (10) @(posedge clk);
        #1 srst = 1'b0;
        for (i = 0; i < 16; i++) begin
            arr_model[i] = 8'($random(seed));
            arr_idx  = 4'(i);
            arr_data = arr_model[i];
            arr_wr   = 1'b1;
            @(posedge clk);
            #1;
        end
        arr_wr = 1'b0;
        for (m = 0; m < 4; m++) begin
            // presence delays of 1 to 7 cycles all overlap the master's sample point
            pres_delay = 8'(1 + $unsigned($random(seed)) % 7);
            q = {mk(0, 0, 5'h00, 8'($random(seed)), 0), mk(0, 0, 5'h00, 8'($random(seed)), 1)};
            run(3'(m), q);
        end
        for (m = 4; m < 8; m++) begin
            pres_delay = 8'(1 + $unsigned($random(seed)) % 7);
            q = {mk(0, 0, 5'h00, 8'hfe, 0), mk(0, 0, 5'h00, 8'($random(seed)), 1)};
            run(3'(m), q);
        end
        q = {mk(1, 1, 5'h04, 8'h00, 0), mk(0, 0, 5'h00, 8'h4e, 1)};
        run(3'd1, q);
        q = {mk(1, 0, 5'h00, 8'h00, 1)};
        run(3'd0, q);
        q = {mk(1, 1, 5'h00, 8'h00, 0), mk(1, 1, 5'h10, 8'h00, 1)};
        run(3'd5, q);
        pres_delay = 8'h06;
        q = {mk(0, 0, 5'h00, 8'h33, 1)};
        run(3'd3, q);
        present_en = 1'b0;
        run(3'd3, q);
        present_en = 1'b1;
        run(3'd0, q);
        summarize();
    end
endmodule
`default_nettype wire
